// >>> common/pmcd_pkg.sv
// package: register map, encodings and timing of the paging message content decoder
package pmcd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register bus
	localparam int ADDR_W = 2;
	localparam int DATA_W = 16;
	localparam logic [1:0] REG_CONFIG = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_COUNT = 2'h2;

	// config fields
	localparam int CFG_ANY_PHASE_BIT = 0;
	localparam int CFG_ALT_CHAR_BIT = 1;
	localparam int CFG_RATE_LSB = 2;
	localparam int CFG_SUPPORT_LSB = 8;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// status fields
	localparam int STAT_OPEN_BIT = 0;
	localparam int STAT_REJECT_BIT = 1;
	localparam int STAT_TIMEOUT_BIT = 2;
	localparam int STAT_VT_LSB = 4;
	localparam int STAT_EFF_LSB = 8;

	// counter fields
	localparam int CNT_ACC_LSB = 0;
	localparam int CNT_REJ_LSB = 8;

	////////////////////////////////////////////////////////////////////////////////
	// rate and modulation combinations
	typedef enum logic [1:0] {
		PMCD_R1600_2L = 2'b00,
		PMCD_R3200_2L = 2'b01,
		PMCD_R3200_4L = 2'b10,
		PMCD_R6400_4L = 2'b11
	} pmcd_rate_e;

	// fragment reassembly state
	typedef enum logic {
		FRAG_IDLE = 1'b0,
		FRAG_OPEN = 1'b1
	} pmcd_frag_e;

	// vector type codes and sub-type fields
	localparam logic [2:0] VT_SHORT_INSTR = 3'h1;
	localparam logic [2:0] VT_SHORT_MSG = 3'h2;
	localparam logic [2:0] VT_NUM_STD = 3'h3;
	localparam logic [2:0] VT_NUM_SPECIAL = 3'h4;
	localparam logic [2:0] VT_ALPHA = 3'h5;
	localparam logic [2:0] VT_NUM_NUMBERED = 3'h7;
	localparam logic [1:0] MT_PLAIN = 2'h0;
	localparam logic [2:0] IT_PLAIN = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// characters
	localparam logic [6:0] CHR_ETX = 7'h03;
	localparam logic [6:0] CHR_CTRL_TOP = 7'h1F;
	localparam logic [6:0] CHR_DEL = 7'h7F;
	localparam logic [3:0] NUM_LAST_DIGIT = 4'h9;
	localparam logic [7:0] ASCII_ZERO = 8'h30;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_HZ = 40000000;
	localparam int MS_PER_SEC = 1000;
	localparam int SEC_PER_MIN = 60;
	localparam int FRAG_HOLD_MIN = 4;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_SEC;
	localparam int FRAG_HOLD_MS = FRAG_HOLD_MIN * SEC_PER_MIN * MS_PER_SEC;

endpackage : pmcd_pkg

// >>> rtl/pmcd_char_map.sv
// character translator: alphanumeric and numeric codes to ascii with display and store flags
`timescale 1ns/100ps
`default_nettype none

module pmcd_char_map (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire logic [6:0] i_code,
	input wire logic i_numeric,
	input wire logic i_alt,
	output logic o_valid,
	output logic [7:0] o_ascii,
	output logic o_display,
	output logic o_store,
	output logic o_end
);
	import pmcd_pkg::*;

	function automatic logic [7:0] pmcd_num_map(input logic [3:0] n, input logic alt);
		logic [7:0] c;
		c = 8'h00;
		if (n <= NUM_LAST_DIGIT)
		begin
			c = ASCII_ZERO | {4'h0, n};
		end
		else
		begin
			unique case (n)
				4'hA: c = alt ? 8'h41 : 8'h00;
				4'hB: c = alt ? 8'h42 : 8'h55;
				4'hC: c = 8'h20;
				4'hD: c = alt ? 8'h43 : 8'h2D;
				4'hE: c = alt ? 8'h44 : 8'h5D;
				4'hF: c = alt ? 8'h45 : 8'h5B;
				default: c = 8'h00;
			endcase
		end
		return c;
	endfunction : pmcd_num_map

	////////////////////////////////////////////////////////////////////////////////
	wire logic [3:0] nib = i_code[3:0];
	wire logic num_spare = !i_alt && (nib == 4'hA);
	wire logic [7:0] num_ascii = pmcd_num_map(nib, i_alt);
	// column is the upper three bits, row the lower four: plain ascii
	wire logic [7:0] alpha_ascii = {1'b0, i_code};
	wire logic is_etx = (i_code == CHR_ETX);
	wire logic is_ctrl = (i_code <= CHR_CTRL_TOP) || (i_code == CHR_DEL);
	// control codes cost no display space but are kept for download, except etx
	wire logic display_w = i_numeric ? !num_spare : !is_ctrl;
	// etx ends the text and is not stored
	wire logic store_w = i_numeric || !is_etx;
	wire logic end_w = !i_numeric && is_etx;
	wire logic [7:0] ascii_w = i_numeric ? num_ascii : alpha_ascii;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_valid <= 1'b0;
			o_ascii <= 8'h00;
			o_display <= 1'b0;
			o_store <= 1'b0;
			o_end <= 1'b0;
		end
		else
		begin
			o_valid <= i_valid;
			o_ascii <= i_valid ? ascii_w : o_ascii;
			o_display <= i_valid && display_w;
			o_store <= i_valid && store_w;
			o_end <= i_valid && end_w;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_alpha_ascii;
		i_valid && !i_numeric && !is_ctrl |=> o_ascii == $past(alpha_ascii) && o_display && o_store;
	endproperty
	a_alpha_ascii: assert property (p_alpha_ascii) else $error("printable alpha code mistranslated");

	property p_ctrl_hidden;
		i_valid && !i_numeric && is_ctrl && !is_etx |=> o_store && !o_display && !o_end;
	endproperty
	a_ctrl_hidden: assert property (p_ctrl_hidden) else $error("control code displayed or dropped");

	property p_num_std;
		i_valid && i_numeric && !i_alt && nib == 4'hB |=> o_ascii == 8'h55 && o_display;
	endproperty
	a_num_std: assert property (p_num_std) else $error("standard numeric 1011 is not U");

	property p_num_alt;
		i_valid && i_numeric && i_alt && nib == 4'hD |=> o_ascii == 8'h43 && o_display;
	endproperty
	a_num_alt: assert property (p_num_alt) else $error("alternate numeric 1101 is not C");

endmodule : pmcd_char_map

`default_nettype wire

// >>> rtl/pmcd_top.sv
// paging message content decoder: header acceptance, fragment reassembly, character output
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

module pmcd_top #(
	parameter int P_MS_CYCLES = pmcd_pkg::MS_CYCLES,
	parameter int P_FRAG_HOLD_MS = pmcd_pkg::FRAG_HOLD_MS
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [pmcd_pkg::ADDR_W-1:0] i_addr,
	input wire logic [pmcd_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [pmcd_pkg::DATA_W-1:0] o_rd_data,
	input wire logic i_hdr_valid,
	input wire logic [2:0] i_vector_type_field,
	input wire logic [1:0] i_message_type_field,
	input wire logic [2:0] i_instruction_type_field,
	input wire logic i_home_phase,
	input wire logic i_frag_next,
	input wire logic i_frag_cont,
	input wire logic i_char_valid,
	input wire logic [6:0] i_char_code,
	output logic o_msg_accept,
	output logic o_msg_reject,
	output logic o_frag_open,
	output logic o_any_phase,
	output logic o_four_level,
	output logic o_baud_3200,
	output logic o_char_valid,
	output logic [7:0] o_char_ascii,
	output logic o_char_display,
	output logic o_char_store,
	output logic o_char_end
);
	import pmcd_pkg::*;

	generate
		if (P_MS_CYCLES < 2 || P_FRAG_HOLD_MS < 2)
		begin : g_bad_param
			$error("pmcd_top: counts must be at least 2");
		end
	endgenerate

	localparam int MS_W = $clog2(P_MS_CYCLES);
	localparam int HOLD_W = $clog2(P_FRAG_HOLD_MS);
	localparam logic [MS_W-1:0] MS_LAST = MS_W'(P_MS_CYCLES - 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(P_FRAG_HOLD_MS - 1);

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic timeout_r;
	logic timeout_nxt;
	logic reject_r;
	logic [2:0] last_vt_r;
	logic [7:0] acc_cnt_r;
	logic [7:0] acc_cnt_nxt;
	logic [7:0] rej_cnt_r;
	logic [7:0] rej_cnt_nxt;
	pmcd_frag_e frag_state_r;
	pmcd_frag_e frag_state_nxt;
	logic [MS_W-1:0] ms_cnt_r;
	logic [MS_W-1:0] ms_cnt_nxt;
	logic [HOLD_W-1:0] hold_cnt_r;
	logic [HOLD_W-1:0] hold_cnt_nxt;
	logic alt_r;
	logic numeric_r;

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	wire logic wr_cfg = i_wr && (i_addr == REG_CONFIG);
	wire logic wr_stat = i_wr && (i_addr == REG_STATUS);
	wire logic wr_cnt = i_wr && (i_addr == REG_COUNT);
	wire logic stat_clr = wr_stat && i_wr_data[STAT_TIMEOUT_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// configuration view
	// one bit chooses the addressing scheme, so only one can ever be in force
	wire logic any_phase = cfg_r[CFG_ANY_PHASE_BIT];
	wire logic cfg_alt = cfg_r[CFG_ALT_CHAR_BIT];
	wire logic [7:0] mask = cfg_r[CFG_SUPPORT_LSB +: 8];
	wire pmcd_rate_e rate = pmcd_rate_e'(cfg_r[CFG_RATE_LSB +: 2]);

	// implied support from the closure of the configured set
	wire logic imp_num = mask[VT_ALPHA];
	wire logic imp_short = mask[VT_NUM_STD] || mask[VT_ALPHA];
	wire logic imp_instr = any_phase && mask[VT_ALPHA];
	wire logic [7:0] eff_mask = mask
		| ({7'h00, imp_instr} << VT_SHORT_INSTR)
		| ({7'h00, imp_short} << VT_SHORT_MSG)
		| ({7'h00, imp_num} << VT_NUM_STD);

	////////////////////////////////////////////////////////////////////////////////
	// header acceptance
	wire logic [2:0] vt = i_vector_type_field;
	wire logic vt_explicit = mask[vt];
	wire logic vt_num_imp = (vt == VT_NUM_STD) && imp_num;
	wire logic vt_short_imp = (vt == VT_SHORT_MSG) && (i_message_type_field == MT_PLAIN)
		&& imp_short;
	wire logic vt_instr_imp = (vt == VT_SHORT_INSTR) && (i_instruction_type_field == IT_PLAIN)
		&& imp_instr;
	wire logic vt_ok = vt_explicit || vt_num_imp || vt_short_imp || vt_instr_imp;
	wire logic phase_ok = any_phase || i_home_phase;
	// a continuation with nothing open has lost its start and cannot be reassembled
	wire logic orphan = i_frag_next && (frag_state_r == FRAG_IDLE);
	wire logic hdr_ok = phase_ok && vt_ok && !orphan;
	wire logic hdr_take = i_hdr_valid && hdr_ok;
	wire logic hdr_drop = i_hdr_valid && !hdr_ok;
	wire logic vt_numeric = (vt == VT_NUM_STD) || (vt == VT_NUM_SPECIAL)
		|| (vt == VT_NUM_NUMBERED);

	////////////////////////////////////////////////////////////////////////////////
	// fragment reassembly
	// the numeric vectors always fit in one frame, so only starts need the flag
	wire logic frag_start = hdr_take && !i_frag_next && i_frag_cont;
	wire logic frag_more = hdr_take && i_frag_next && i_frag_cont;
	wire logic frag_last = hdr_take && i_frag_next && !i_frag_cont;
	wire logic refresh = frag_start || frag_more;
	wire logic frag_open = (frag_state_r == FRAG_OPEN);
	wire logic ms_tick = frag_open && (ms_cnt_r == MS_LAST);
	// a fragment arriving on the expiry cycle wins, so no late fragment is lost
	wire logic expire = ms_tick && (hold_cnt_r == HOLD_LAST) && !refresh;

	always_comb
	begin
		frag_state_nxt = frag_state_r;
		if (refresh)
		begin
			frag_state_nxt = FRAG_OPEN;
		end
		else if (frag_last || expire)
		begin
			frag_state_nxt = FRAG_IDLE;
		end
	end

	// hold timer counts whole milliseconds since the last fragment
	assign ms_cnt_nxt = (refresh || !frag_open || ms_tick) ? '0 : ms_cnt_r + MS_W'(1);
	assign hold_cnt_nxt = (refresh || !frag_open) ? '0
		: (ms_tick ? hold_cnt_r + HOLD_W'(1) : hold_cnt_r);

	////////////////////////////////////////////////////////////////////////////////
	// status and counters
	assign cfg_nxt = wr_cfg ? i_wr_data : cfg_r;
	// set wins over the software clear
	assign timeout_nxt = expire || (timeout_r && !stat_clr);
	assign acc_cnt_nxt = (wr_cnt ? 8'h00 : acc_cnt_r) + {7'h00, hdr_take};
	assign rej_cnt_nxt = (wr_cnt ? 8'h00 : rej_cnt_r) + {7'h00, hdr_drop};

	wire logic [15:0] stat_word = {eff_mask, 1'b0, last_vt_r, 1'b0, timeout_r, reject_r,
		frag_open};
	wire logic [15:0] cnt_word = {rej_cnt_r, acc_cnt_r};
	wire logic [15:0] rd_mux = (i_addr == REG_CONFIG) ? cfg_r
		: (i_addr == REG_STATUS) ? stat_word
		: (i_addr == REG_COUNT) ? cnt_word : 16'h0000;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			cfg_r <= CFG_RESET;
			timeout_r <= 1'b0;
			acc_cnt_r <= 8'h00;
			rej_cnt_r <= 8'h00;
			o_rd_data <= 16'h0000;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			timeout_r <= timeout_nxt;
			acc_cnt_r <= acc_cnt_nxt;
			rej_cnt_r <= rej_cnt_nxt;
			o_rd_data <= i_rd ? rd_mux : 16'h0000;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			frag_state_r <= FRAG_IDLE;
			ms_cnt_r <= '0;
			hold_cnt_r <= '0;
		end
		else
		begin
			frag_state_r <= frag_state_nxt;
			ms_cnt_r <= ms_cnt_nxt;
			hold_cnt_r <= hold_cnt_nxt;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			reject_r <= 1'b0;
			last_vt_r <= 3'h0;
			o_msg_accept <= 1'b0;
			o_msg_reject <= 1'b0;
		end
		else
		begin
			reject_r <= i_hdr_valid ? hdr_drop : reject_r;
			last_vt_r <= i_hdr_valid ? vt : last_vt_r;
			o_msg_accept <= hdr_take;
			o_msg_reject <= hdr_drop;
		end
	end

	// option is sampled on every accepted header, fragments included, so a config write mid-message cannot
	// change the table under the characters already flowing
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			alt_r <= 1'b0;
			numeric_r <= 1'b0;
		end
		else if (hdr_take)
		begin
			alt_r <= cfg_alt;
			numeric_r <= vt_numeric;
		end
	end

	// rate field steers the demodulator: symbol rate and level count
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_any_phase <= 1'b0;
			o_four_level <= 1'b0;
			o_baud_3200 <= 1'b0;
			o_frag_open <= 1'b0;
		end
		else
		begin
			o_any_phase <= any_phase;
			o_four_level <= (rate == PMCD_R3200_4L) || (rate == PMCD_R6400_4L);
			o_baud_3200 <= (rate == PMCD_R3200_2L) || (rate == PMCD_R6400_4L);
			o_frag_open <= frag_state_nxt == FRAG_OPEN;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// character translation
	pmcd_char_map u_char_map (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_valid(i_char_valid),
		.i_code(i_char_code),
		.i_numeric(numeric_r),
		.i_alt(alt_r),
		.o_valid(o_char_valid),
		.o_ascii(o_char_ascii),
		.o_display(o_char_display),
		.o_store(o_char_store),
		.o_end(o_char_end)
	);

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_addr_scheme;
		i_hdr_valid && !any_phase && !i_home_phase |=> o_msg_reject && !o_msg_accept;
	endproperty
	a_addr_scheme: assert property (p_addr_scheme) else $error("off-phase header taken");

	property p_num_short;
		i_hdr_valid && i_home_phase && !orphan && mask[VT_NUM_STD] && vt == VT_SHORT_MSG
			&& i_message_type_field == MT_PLAIN |=> o_msg_accept;
	endproperty
	a_num_short: assert property (p_num_short) else $error("short message not implied");

	property p_alpha_num;
		i_hdr_valid && i_home_phase && !orphan && mask[VT_ALPHA] && vt == VT_NUM_STD
			|=> o_msg_accept && !o_msg_reject;
	endproperty
	a_alpha_num: assert property (p_alpha_num) else $error("numeric not implied");

	property p_alpha_instr;
		i_hdr_valid && any_phase && !orphan && mask[VT_ALPHA] && vt == VT_SHORT_INSTR
			&& i_instruction_type_field == IT_PLAIN |=> o_msg_accept;
	endproperty
	a_alpha_instr: assert property (p_alpha_instr) else $error("instruction not implied");

	property p_rate_6400;
		wr_cfg && i_wr_data[CFG_RATE_LSB +: 2] == PMCD_R6400_4L |=> ##1 o_four_level && o_baud_3200;
	endproperty
	a_rate_6400: assert property (p_rate_6400) else $error("6400 four-level not selected");

	property p_frag_hold;
		frag_open && !i_hdr_valid && hold_cnt_r != HOLD_LAST |=> frag_open && o_frag_open;
	endproperty
	a_frag_hold: assert property (p_frag_hold) else $error("reassembly dropped early");

	property p_alt_latch;
		(hdr_take ##1 !i_hdr_valid [*3]) |-> alt_r == $past(cfg_alt, 3);
	endproperty
	a_alt_latch: assert property (p_alt_latch) else $error("alternate option not held");

	property p_unsupported;
		i_hdr_valid && !mask[vt] && vt != VT_SHORT_INSTR && vt != VT_SHORT_MSG && vt != VT_NUM_STD
			|=> o_msg_reject && reject_r;
	endproperty
	a_unsupported: assert property (p_unsupported) else $error("unsupported vector taken");

endmodule : pmcd_top

`default_nettype wire

// >>> dv/pmcd_enc_model.sv
// paging encoder model: drives message headers and characters into the decoder
`timescale 1ns/100ps
`default_nettype none

module pmcd_enc_model (
	input wire logic i_clk,
	output logic o_hdr_valid,
	output logic [2:0] o_vt,
	output logic [1:0] o_mt,
	output logic [2:0] o_it,
	output logic o_home,
	output logic o_next,
	output logic o_cont,
	output logic o_char_valid,
	output logic [6:0] o_char_code
);
	import pmcd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// no address or number fields cross this port, so reuse and numbering stay clean
	initial
	begin
		o_hdr_valid = 1'b0;
		o_vt = 3'h0;
		o_mt = 2'h0;
		o_it = 3'h0;
		o_home = 1'b0;
		o_next = 1'b0;
		o_cont = 1'b0;
		o_char_valid = 1'b0;
		o_char_code = 7'h00;
	end

	task automatic send_hdr(input logic [2:0] vt, input logic [1:0] mt, input logic [2:0] it,
		input logic home, input logic nxt, input logic cont);
		logic numeric;
		numeric = (vt == VT_NUM_STD) || (vt == VT_NUM_SPECIAL) || (vt == VT_NUM_NUMBERED);
		@(posedge i_clk);
		o_hdr_valid <= 1'b1;
		o_vt <= vt;
		o_mt <= mt;
		o_it <= it;
		o_home <= home;
		o_next <= nxt & !numeric; // numeric vectors stay in one frame
		o_cont <= cont & !numeric;
		@(posedge i_clk);
		o_hdr_valid <= 1'b0;
		// released type fields do not keep their last value
		o_vt <= ~vt;
		o_mt <= ~mt;
		o_it <= ~it;
	endtask : send_hdr

	// characters go whole, one 7-bit code per strobe
	task automatic send_char(input logic [6:0] c);
		@(posedge i_clk);
		o_char_valid <= 1'b1;
		o_char_code <= c;
		@(posedge i_clk);
		o_char_valid <= 1'b0;
		o_char_code <= ~c;
	endtask : send_char

endmodule : pmcd_enc_model
`default_nettype wire

// >>> dv/pmcd_top_tb.sv
// self-checking bench of the paging message content decoder
`timescale 1ns/100ps
`default_nettype none

module pmcd_top_tb;
	import pmcd_pkg::*;
	logic i_clk;
	logic i_rst_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rd_data;
	logic wr, rd, hv, home_ph, nx, ct, cv;
	logic [2:0] vtf, itf;
	logic [1:0] mtf;
	logic [6:0] code;
	logic acc, rej, fopen, anyp, four, b3200, ov, disp, stor, fin;
	logic [7:0] asc;
	int err_count = 0;
	int total_checks = 0;

	pmcd_top #(.P_MS_CYCLES(4), .P_FRAG_HOLD_MS(8)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data),
		.i_hdr_valid(hv), .i_vector_type_field(vtf), .i_message_type_field(mtf),
		.i_instruction_type_field(itf), .i_home_phase(home_ph), .i_frag_next(nx),
		.i_frag_cont(ct), .i_char_valid(cv), .i_char_code(code), .o_msg_accept(acc),
		.o_msg_reject(rej), .o_frag_open(fopen), .o_any_phase(anyp), .o_four_level(four),
		.o_baud_3200(b3200), .o_char_valid(ov), .o_char_ascii(asc), .o_char_display(disp),
		.o_char_store(stor), .o_char_end(fin));

	pmcd_enc_model enc_u (.i_clk(i_clk), .o_hdr_valid(hv), .o_vt(vtf), .o_mt(mtf), .o_it(itf),
		.o_home(home_ph), .o_next(nx), .o_cont(ct), .o_char_valid(cv), .o_char_code(code));

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge i_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask : reg_wr

	// read data are taken in the one cycle where they stand
	task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge i_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge i_clk);
		rd <= 1'b0;
		#1;
		d = rd_data;
	endtask : reg_rd

	task automatic hdr(input logic [2:0] vt, input logic [1:0] mt, input logic [2:0] it,
		input logic hm, input logic n, input logic c, input logic exp);
		enc_u.send_hdr(vt, mt, it, hm, n, c);
		#1;
		check("accept", 16'(exp), 16'(acc));
		check("reject", 16'(!exp), 16'(rej));
	endtask : hdr

	task automatic chr(input logic [6:0] c, input logic [11:0] exp);
		enc_u.send_char(c);
		#1;
		check("char", {4'h0, exp}, {4'h0, ov, disp, stor, fin, asc});
	endtask : chr

	function automatic logic sup(logic [7:0] m, logic ap, logic [2:0] vt, logic [1:0] mt,
		logic [2:0] it);
		return m[vt] | (vt == VT_NUM_STD && m[5]) | (vt == VT_SHORT_MSG && mt == MT_PLAIN
			&& (m[3] | m[5])) | (vt == VT_SHORT_INSTR && it == IT_PLAIN && ap && m[5]);
	endfunction : sup

	function automatic logic [11:0] alpha_exp(logic [6:0] c);
		logic shown;
		shown = (c > CHR_CTRL_TOP) && (c != CHR_DEL);
		return {1'b1, shown, c != CHR_ETX, c == CHR_ETX, 1'b0, c};
	endfunction : alpha_exp

	function automatic logic [11:0] num_exp(logic alt, logic [3:0] c);
		string t;
		t = alt ? "AB CDE" : "?U -][";
		if (!alt && c == 4'hA)
			return {4'hA, 8'h00};
		if (c <= NUM_LAST_DIGIT)
			return {4'hE, ASCII_ZERO + 8'(c)};
		return {4'hE, t[c - 4'hA]};
	endfunction : num_exp

	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge i_clk);
		err_count++;
		$display("ERROR watchdog expected done seen hang");
		finish_test();
	end

	initial
	begin
		logic [15:0] d, m;
		logic [2:0] vt, it;
		logic [1:0] mt;
		logic hm, ex;
		logic [7:0] na, nr;
		int seed;
		i_rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 2'h0;
		wdata = 16'h0000;
		seed = $urandom(87);
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		reg_rd(REG_CONFIG, d);
		check("config reset", CFG_RESET, d);
		reg_wr(REG_CONFIG, 16'hA50F);
		reg_wr(2'h3, 16'hFFFF);
		reg_rd(REG_CONFIG, d);
		check("config", 16'hA50F, d);
		@(posedge i_clk);
		#1;
		check("read idle", 16'h0000, rd_data);
		reg_rd(2'h3, d);
		check("unmapped", 16'h0000, d);
		for (int r = 0; r < 4; r++)
		begin
			reg_wr(REG_CONFIG, 16'(r << 2) | 16'(r & 1));
			@(posedge i_clk);
			#1;
			check("four level", 16'(r[1]), 16'(four));
			check("baud", 16'(r[0]), 16'(b3200));
			check("any phase", 16'(r[0]), 16'(anyp));
		end
		$display("test registers done");
		// support set, random with implied-vector corners first
		reg_wr(REG_COUNT, 16'h0000);
		na = 8'h00;
		nr = 8'h00;
		for (int i = 0; i < 60; i++)
		begin
			m = 16'($urandom);
			vt = 3'($urandom);
			mt = 2'($urandom);
			it = 3'($urandom);
			hm = 1'($urandom);
			if (i < 8)
			begin
				m[15:8] = i[0] ? 8'h08 : 8'h20;
				vt = 3'(i[2:1]) + 3'h1;
				mt = MT_PLAIN;
				it = IT_PLAIN;
				hm = 1'b1;
			end
			reg_wr(REG_CONFIG, {m[15:8], 7'h00, m[0]});
			ex = sup(m[15:8], m[0], vt, mt, it) && (m[0] || hm);
			hdr(vt, mt, it, hm, 1'b0, 1'b0, ex);
			reg_rd(REG_STATUS, d);
			check("status", {m[15:8] | {4'h0, m[13], m[11] | m[13], m[0] & m[13], 1'b0},
				1'b0, vt, 2'b00, ~ex, 1'b0}, d);
			if (ex)
				na++;
			else
				nr++;
		end
		reg_rd(REG_COUNT, d);
		check("counts", {nr, na}, d);
		$display("test support done");
		// fragments: hold is 8 ms of 4 cycles
		reg_wr(REG_CONFIG, 16'h2001);
		hdr(VT_ALPHA, MT_PLAIN, IT_PLAIN, 1'b1, 1'b1, 1'b1, 1'b0);
		hdr(VT_ALPHA, MT_PLAIN, IT_PLAIN, 1'b1, 1'b0, 1'b1, 1'b1);
		repeat (20) @(posedge i_clk);
		#1;
		check("open", 16'h0001, 16'(fopen));
		hdr(VT_ALPHA, MT_PLAIN, IT_PLAIN, 1'b1, 1'b1, 1'b1, 1'b1);
		repeat (25) @(posedge i_clk);
		#1;
		check("open held", 16'h0001, 16'(fopen));
		repeat (20) @(posedge i_clk);
		#1;
		check("expired", 16'h0000, 16'(fopen));
		reg_rd(REG_STATUS, d);
		check("timeout", 16'h0004, d & 16'h0005);
		reg_wr(REG_STATUS, 16'h0004);
		reg_rd(REG_STATUS, d);
		check("timeout clear", 16'h0000, d & 16'h0004);
		hdr(VT_ALPHA, MT_PLAIN, IT_PLAIN, 1'b1, 1'b0, 1'b1, 1'b1);
		hdr(VT_ALPHA, MT_PLAIN, IT_PLAIN, 1'b1, 1'b1, 1'b0, 1'b1);
		@(posedge i_clk);
		#1;
		check("closed", 16'h0000, 16'(fopen));
		$display("test fragments done");
		// numeric tables, option flipped after the header to prove latching
		for (int a = 0; a < 2; a++)
		begin
			reg_wr(REG_CONFIG, 16'h0801 | 16'(a << 1));
			hdr(VT_NUM_STD, MT_PLAIN, IT_PLAIN, 1'b1, 1'b0, 1'b0, 1'b1);
			reg_wr(REG_CONFIG, 16'h0801 | 16'((1 - a) << 1));
			for (int c = 0; c < 16; c++)
				chr(7'(c), num_exp(a[0], 4'(c)));
		end
		reg_wr(REG_CONFIG, 16'h2001);
		hdr(VT_ALPHA, MT_PLAIN, IT_PLAIN, 1'b1, 1'b0, 1'b0, 1'b1);
		for (int c = 0; c < 128; c++)
			chr(7'(c), alpha_exp(7'(c)));
		chr(CHR_ETX, alpha_exp(CHR_ETX));
		$display("test characters done");
		finish_test();
	end

endmodule : pmcd_top_tb
`default_nettype wire
